/* File: t16ri_pkg.sv */
// Purpose: constants for the two-unit 16-bit timer register interface
// Assumes: byte-wide i/o bus, one clock, asynchronous active-low reset
// Notes:   addresses are local i/o offsets
package t16ri_pkg;
    // ****************************************
    // addresses
    // ****************************************
    localparam logic [7:0] T16RI_UNIT_BASE_1 = 8'h00;
    localparam logic [7:0] T16RI_UNIT_BASE_3 = 8'h10;
    localparam logic [3:0] T16RI_OFS_CNT_L = 4'h0;
    localparam logic [3:0] T16RI_OFS_CNT_H = 4'h1;
    localparam logic [3:0] T16RI_OFS_CAP_L = 4'h2;
    localparam logic [3:0] T16RI_OFS_CAP_H = 4'h3;
    localparam logic [3:0] T16RI_OFS_CMP_L = 4'h4;
    localparam logic [7:0] T16RI_ADDR_MASK = 8'h20;
    localparam logic [7:0] T16RI_ADDR_EMASK = 8'h21;
    localparam logic [7:0] T16RI_ADDR_FLAGS = 8'h22;
    localparam logic [7:0] T16RI_ADDR_EFLAGS = 8'h23;
    // ****************************************
    // event kinds and bit positions
    // ****************************************
    localparam int T16RI_K_CAP = 0;
    localparam int T16RI_K_A = 1;
    localparam int T16RI_K_B = 2;
    localparam int T16RI_K_C = 3;
    localparam int T16RI_K_OVF = 4;
    localparam int T16RI_NK = 5;
    localparam logic [2:0] T16RI_POS_CAP = 3'h5;
    localparam logic [2:0] T16RI_POS_A = 3'h4;
    localparam logic [2:0] T16RI_POS_B = 3'h3;
    localparam logic [2:0] T16RI_POS_OVF = 3'h2;
    localparam logic [2:0] T16RI_POS_T3C = 3'h1;
    localparam logic [2:0] T16RI_POS_T1C = 3'h0;
    localparam logic [7:0] T16RI_EMASK_RW = 8'h3f;
    localparam logic [15:0] T16RI_ONE = 16'h0001;
    localparam logic [15:0] T16RI_RST16 = 16'h0000;

    typedef struct packed {
        logic [1:0][15:0] counter;
        logic [1:0][2:0][15:0] compare;
        logic [1:0][15:0] capture;
        logic [7:0] temp;
        logic [1:0] block;
        logic [7:0] mask;
        logic [7:0] emask;
        logic [1:0][4:0] flag;
        logic [7:0] rdata;
        logic [1:0][4:0] irq;
        logic [1:0][2:0] match;
        logic [1:0][15:0] ceiling;
    } t16ri_state_t;
endpackage

/* File: t16ri_regs.sv */
// Purpose: register interface of two 16-bit timer/counters
// Assumes: all inputs synchronous to core_clk; tick is the timer clock enable
// Notes:   io_rdata answers one cycle after io_rd
`timescale 1ns/1ps
module t16ri_regs
    import t16ri_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rdata,
    input wire logic [1:0] timer_tick,
    input wire logic [1:0] capture_input_pin,
    input wire logic comparator_event,
    input wire logic comparator_select,
    input wire logic [1:0] ceiling_is_capture,
    input wire logic [1:0] overflow_event,
    input wire logic [1:0][4:0] vector_ack,
    input wire logic global_irq_enable,
    input wire logic legacy_mode,
    output logic [1:0][4:0] irq_request,
    output logic [1:0][2:0] match_pulse,
    output logic [1:0][15:0] count_ceiling,
    output logic [1:0][15:0] counter_value
);
    // ****************************************
    // helpers
    // ****************************************
    // {in extended register, bit position} of unit u, event kind k
    function automatic logic [3:0] src_pos(input int u, input int k);
        logic [3:0] r;
        r = {1'b1, T16RI_POS_T1C};
        case (k)
            T16RI_K_CAP: r = {u[0], T16RI_POS_CAP};
            T16RI_K_A: r = {u[0], T16RI_POS_A};
            T16RI_K_B: r = {u[0], T16RI_POS_B};
            T16RI_K_OVF: r = {u[0], T16RI_POS_OVF};
            T16RI_K_C: r = u[0] ? {1'b1, T16RI_POS_T3C} : {1'b1, T16RI_POS_T1C};
            default: r = {1'b1, T16RI_POS_T1C};
        endcase
        return r;
    endfunction

    function automatic logic [7:0] unit_base(input int u);
        return u[0] ? T16RI_UNIT_BASE_3 : T16RI_UNIT_BASE_1;
    endfunction

    t16ri_state_t s;
    t16ri_state_t next_s;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [7:0] base;
        logic [3:0] p;
        logic [3:0] ofs;
        logic hit;
        logic cap_ev;
        logic [4:0] set;
        logic [4:0] clr;
        logic [7:0] flags_rd;
        logic [7:0] eflags_rd;
        base = 8'h00;
        p = 4'h0;
        ofs = 4'h0;
        hit = 1'b0;
        cap_ev = 1'b0;
        set = 5'h00;
        clr = 5'h00;
        flags_rd = 8'h00;
        eflags_rd = 8'h00;
        next_s = s;
        next_s.match = '0;
        next_s.rdata = 8'h00;

        // flag views, one bit per source
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < T16RI_NK; k++) begin
                p = src_pos(u, k);
                if (p[3]) begin
                    eflags_rd[p[2:0]] = s.flag[u][k];
                end else begin
                    flags_rd[p[2:0]] = s.flag[u][k];
                end
            end
        end

        for (int u = 0; u < 2; u++) begin
            base = unit_base(u);
            ofs = io_addr[3:0];
            hit = (io_addr[7:4] == base[7:4]);
            set = 5'h00;
            clr = vector_ack[u];

            // counter advances on its timer tick; wraps at ceiling when selected
            if (timer_tick[u]) begin
                if (ceiling_is_capture[u] && s.counter[u] == s.capture[u]) begin
                    next_s.counter[u] = T16RI_RST16;
                end else begin
                    next_s.counter[u] = s.counter[u] + T16RI_ONE;
                end
                next_s.block[u] = 1'b0;
                for (int c = 0; c < 3; c++) begin
                    if (!s.block[u] && s.counter[u] == s.compare[u][c]) begin
                        next_s.match[u][c] = 1'b1;
                        set[T16RI_K_A + c] = 1'b1;
                    end
                end
                if (ceiling_is_capture[u] && s.counter[u] == s.capture[u]) begin
                    set[T16RI_K_CAP] = 1'b1;
                end
            end

            // capture source; pin is disconnected while capture is the ceiling
            cap_ev = (u == 0 && comparator_select) ? comparator_event : capture_input_pin[u];
            if (cap_ev && !ceiling_is_capture[u]) begin
                next_s.capture[u] = s.counter[u];
                set[T16RI_K_CAP] = 1'b1;
            end
            if (overflow_event[u]) begin
                set[T16RI_K_OVF] = 1'b1;
            end
            next_s.ceiling[u] = ceiling_is_capture[u] ? s.capture[u] : 16'hffff;

            // 16-bit accesses: write high to latch, low commits pair
            if (io_wr && hit) begin
                if (ofs == T16RI_OFS_CNT_L) begin
                    next_s.counter[u] = {s.temp, io_wdata};
                    next_s.block[u] = 1'b1;
                end
                if (ofs == T16RI_OFS_CAP_L) begin
                    next_s.capture[u] = {s.temp, io_wdata};
                end
                for (int c = 0; c < 3; c++) begin
                    if (ofs == T16RI_OFS_CMP_L + 4'(2 * c)) begin
                        next_s.compare[u][c] = {s.temp, io_wdata};
                    end
                end
            end
            if (io_rd && hit) begin
                if (ofs == T16RI_OFS_CNT_L) begin
                    next_s.rdata = s.counter[u][7:0];
                    next_s.temp = s.counter[u][15:8];
                end
                if (ofs == T16RI_OFS_CAP_L) begin
                    next_s.rdata = s.capture[u][7:0];
                    next_s.temp = s.capture[u][15:8];
                end
                if (ofs == T16RI_OFS_CNT_H || ofs == T16RI_OFS_CAP_H) begin
                    next_s.rdata = s.temp;
                end
                for (int c = 0; c < 3; c++) begin
                    if (ofs == T16RI_OFS_CMP_L + 4'(2 * c)) begin
                        next_s.rdata = s.compare[u][c][7:0];
                    end
                    if (ofs == T16RI_OFS_CMP_L + 4'(2 * c + 1)) begin
                        next_s.rdata = s.compare[u][c][15:8];
                    end
                end
            end

            // write-one clears; a same-cycle set wins
            for (int k = 0; k < T16RI_NK; k++) begin
                p = src_pos(u, k);
                if (io_wr && io_wdata[p[2:0]]
                        && io_addr == (p[3] ? T16RI_ADDR_EFLAGS : T16RI_ADDR_FLAGS)) begin
                    clr[k] = 1'b1;
                end
                next_s.flag[u][k] = set[k] | (s.flag[u][k] & ~clr[k]);
                next_s.irq[u][k] = s.flag[u][k] && global_irq_enable
                    && (p[3] ? s.emask[p[2:0]] : s.mask[p[2:0]]);
            end
        end

        // high-byte writes go to the shared latch
        if (io_wr && io_addr[7:5] == 3'h0 && io_addr[0]) begin
            next_s.temp = io_wdata;
        end
        if (io_wr && io_addr == T16RI_ADDR_MASK) begin
            next_s.mask = io_wdata;
        end
        if (io_wr && io_addr == T16RI_ADDR_EMASK && !legacy_mode) begin
            next_s.emask = io_wdata & T16RI_EMASK_RW;
        end
        if (io_rd) begin
            case (io_addr)
                T16RI_ADDR_MASK: next_s.rdata = s.mask;
                T16RI_ADDR_EMASK: next_s.rdata = legacy_mode ? 8'h00 : s.emask;
                T16RI_ADDR_FLAGS: next_s.rdata = flags_rd;
                T16RI_ADDR_EFLAGS: next_s.rdata = eflags_rd;
                default: ;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign io_rdata = s.rdata;
    assign irq_request = s.irq;
    assign match_pulse = s.match;
    assign count_ceiling = s.ceiling;
    assign counter_value = s.counter;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_cnt_low_read: assert property (
        io_rd && io_addr == T16RI_UNIT_BASE_1 + 8'(T16RI_OFS_CNT_L) && !io_wr
        |=> s.temp == $past(s.counter[0][15:8]) && io_rdata == $past(s.counter[0][7:0]))
        else $error("counter low read did not latch high byte");
    a_block_after_wr: assert property (
        io_wr && io_addr == T16RI_UNIT_BASE_1 + 8'(T16RI_OFS_CNT_L)
        ##1 timer_tick[0] |=> match_pulse[0] == 3'h0)
        else $error("match not blocked after counter write");
    a_match_flag: assert property (
        timer_tick[0] && !s.block[0] && s.counter[0] == s.compare[0][0]
        |=> s.flag[0][T16RI_K_A] && match_pulse[0][0])
        else $error("compare A match not flagged next cycle");
    a_no_spur_match: assert property (
        !timer_tick[1] |=> match_pulse[1] == 3'h0)
        else $error("match without timer tick");
    a_cmp_pair: assert property (
        io_wr && io_addr == T16RI_UNIT_BASE_3 + 8'(T16RI_OFS_CMP_L)
        |=> s.compare[1][0] == {$past(s.temp), $past(io_wdata)})
        else $error("compare pair write wrong");
    a_capture_copy: assert property (
        capture_input_pin[1] && !ceiling_is_capture[1] && !io_wr
        |=> s.capture[1] == $past(s.counter[1]) && s.flag[1][T16RI_K_CAP])
        else $error("capture did not copy counter");
    a_ceiling_out: assert property (
        ceiling_is_capture[0] |=> count_ceiling[0] == $past(s.capture[0]))
        else $error("ceiling not taken from capture");
    a_irq_three: assert property (
        irq_request[0][T16RI_K_CAP] |-> $past(global_irq_enable)
        && $past(s.mask[T16RI_POS_CAP]) && $past(s.flag[0][T16RI_K_CAP]))
        else $error("irq without all three conditions");
    a_emask_legacy: assert property (
        legacy_mode |=> $stable(s.emask))
        else $error("extended mask changed in legacy mode");
    a_emask_resvd: assert property (
        s.emask[7:6] == 2'h0)
        else $error("extended mask reserved bits set");
    a_flag_ack: assert property (
        vector_ack[1][T16RI_K_OVF] && !overflow_event[1] |=> !s.flag[1][T16RI_K_OVF])
        else $error("overflow flag not cleared by vector");
    a_t1c_ext: assert property (
        io_rd && io_addr == T16RI_ADDR_EFLAGS
        |=> io_rdata[T16RI_POS_T1C] == $past(s.flag[0][T16RI_K_C]))
        else $error("timer 1 compare C flag not in extended register");
    a_cap_low_read: assert property (
        io_rd && io_addr == T16RI_UNIT_BASE_3 + 8'(T16RI_OFS_CAP_L) && !io_wr
        |=> s.temp == $past(s.capture[1][15:8]) && io_rdata == $past(s.capture[1][7:0]))
        else $error("capture low read did not latch high byte");
    a_high_latch: assert property (
        io_wr && io_addr == T16RI_UNIT_BASE_1 + 8'(T16RI_OFS_CNT_H)
        |=> s.temp == $past(io_wdata))
        else $error("high byte write missed the shared latch");
    a_high_read: assert property (
        io_rd && io_addr == T16RI_UNIT_BASE_1 + 8'(T16RI_OFS_CNT_H)
        |=> io_rdata == $past(s.temp))
        else $error("counter high read did not return the latch");
    a_ceil_flag: assert property (
        timer_tick[0] && ceiling_is_capture[0] && s.counter[0] == s.capture[0] && !io_wr
        |=> s.flag[0][T16RI_K_CAP] && counter_value[0] == T16RI_RST16)
        else $error("ceiling reach did not wrap or flag");
    a_flag_map: assert property (
        io_rd && io_addr == T16RI_ADDR_FLAGS
        |=> io_rdata[T16RI_POS_A] == $past(s.flag[0][T16RI_K_A])
        && io_rdata[T16RI_POS_OVF] == $past(s.flag[0][T16RI_K_OVF]))
        else $error("timer 1 flags misplaced");
    a_t3_ext: assert property (
        io_rd && io_addr == T16RI_ADDR_EFLAGS
        |=> io_rdata[T16RI_POS_CAP] == $past(s.flag[1][T16RI_K_CAP])
        && io_rdata[T16RI_POS_OVF] == $past(s.flag[1][T16RI_K_OVF]))
        else $error("timer 3 flags not in extended register");
    a_emask_hidden: assert property (
        io_rd && io_addr == T16RI_ADDR_EMASK && legacy_mode |=> io_rdata == 8'h00)
        else $error("extended mask visible in legacy mode");
    a_t3_irq: assert property (
        irq_request[1][T16RI_K_OVF] |-> $past(global_irq_enable)
        && $past(s.emask[T16RI_POS_OVF]) && $past(s.flag[1][T16RI_K_OVF]))
        else $error("timer 3 overflow irq without its enable");
    a_t1_irq_a: assert property (
        irq_request[0][T16RI_K_A] |-> $past(global_irq_enable)
        && $past(s.mask[T16RI_POS_A]) && $past(s.flag[0][T16RI_K_A]))
        else $error("timer 1 compare A irq without its enable");
    a_cmp_capture: assert property (
        comparator_select && comparator_event && !ceiling_is_capture[0] && !io_wr
        |=> s.capture[0] == $past(s.counter[0]) && s.flag[0][T16RI_K_CAP])
        else $error("comparator event did not capture counter");
    // read data stands one cycle only, so a stale byte is never taken twice
    a_rdata_idle: assert property (
        !io_rd |=> io_rdata == 8'h00)
        else $error("read data held without a read");

    c_capture: cover property (capture_input_pin[0] ##1 s.flag[0][T16RI_K_CAP]);
    c_match_irq: cover property (s.match[1][2] ##[1:3] irq_request[1][T16RI_K_C]);
    c_block: cover property (s.block[0] && timer_tick[0]);
    c_set_clr: cover property (overflow_event[0] && vector_ack[0][T16RI_K_OVF]);
    c_ceil_wrap: cover property (timer_tick[0] && ceiling_is_capture[0]
        && s.counter[0] == s.capture[0]);
endmodule

/* File: t16ri_vec_model.sv */
// Purpose: cpu-side model that executes timer interrupt vectors
// Assumes: irq_request is a registered level, one clock domain
// Notes:   acks only while ack_en is high, two pulses per request because irq_request falls two cycles after the ack
`timescale 1ns/1ps
module t16ri_vec_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ack_en,
    input wire logic [1:0][4:0] irq_request,
    output logic [1:0][4:0] vector_ack
);
    // ****************************************
    // vector execution
    // ****************************************
    // masking with last ack skips one cycle only; irq_request still stands the cycle after, so a second pulse follows
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_ack <= '0;
        end else begin
            vector_ack <= ack_en ? (irq_request & ~vector_ack) : '0;
        end
    end
endmodule

/* File: timer16_register_interface_tb_top.sv */
// Purpose: directed bench for the timer register interface
// Assumes: io_rdata is valid in the cycle after the read edge
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module timer16_register_interface_tb_top;
    import t16ri_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_rdata;
    logic [1:0] timer_tick = 2'h0;
    logic [1:0] capture_input_pin = 2'h0;
    logic [1:0] ceiling_is_capture = 2'h0;
    logic [1:0] overflow_event = 2'h0;
    logic [1:0][4:0] vector_ack;
    logic global_irq_enable = 1'b0;
    logic legacy_mode = 1'b0;
    logic ack_en = 1'b0;
    logic comparator_event = 1'b0;
    logic comparator_select = 1'b0;
    logic [1:0][4:0] irq_request;
    logic [1:0][2:0] match_pulse;
    logic [1:0][15:0] count_ceiling;
    logic [1:0][15:0] counter_value;
    int bad_count = 0;
    int tests_run = 0;

    t16ri_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .timer_tick(timer_tick), .capture_input_pin(capture_input_pin),
        .comparator_event(comparator_event), .comparator_select(comparator_select),
        .ceiling_is_capture(ceiling_is_capture), .overflow_event(overflow_event),
        .vector_ack(vector_ack), .global_irq_enable(global_irq_enable),
        .legacy_mode(legacy_mode), .irq_request(irq_request), .match_pulse(match_pulse),
        .count_ceiling(count_ceiling), .counter_value(counter_value));

    t16ri_vec_model i_vec (.core_clk(core_clk), .rst_b(rst_b), .ack_en(ack_en),
        .irq_request(irq_request), .vector_ack(vector_ack));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge core_clk);
        #1;
        io_wr = 1'b0;
    endtask

    // data is sampled in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge core_clk);
        #1;
        io_rd = 1'b0;
        chk8(io_rdata, exp);
    endtask

    task automatic pulse_tick(input int u);
        @(posedge core_clk);
        #1;
        timer_tick[u] = 1'b1;
        @(posedge core_clk);
        #1;
        timer_tick[u] = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        #200000;
        bad_count++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h00);
        rd(8'h05, 8'h00);
        wr(8'h05, 8'h12);
        wr(8'h04, 8'h36);
        rd(8'h04, 8'h36);
        rd(8'h05, 8'h12);
        // counter equal to compare A, but first tick after write is blocked
        wr(8'h01, 8'h12);
        wr(8'h00, 8'h36);
        rd(8'h00, 8'h36);
        rd(8'h01, 8'h12);
        pulse_tick(0);
        chk8({5'h00, match_pulse[0]}, 8'h00);
        rd(8'h22, 8'h00);
        wr(8'h20, 8'h30);
        wr(8'h01, 8'h12);
        wr(8'h00, 8'h35);
        pulse_tick(0);
        pulse_tick(0);
        chk8({5'h00, match_pulse[0]}, 8'h01);
        rd(8'h22, 8'h10);
        chk8({7'h00, irq_request[0][1]}, 8'h00);
        global_irq_enable = 1'b1;
        idle(2);
        chk8({7'h00, irq_request[0][1]}, 8'h01);
        chk8(counter_value[0][7:0], 8'h37);
        wr(8'h22, 8'h10);
        rd(8'h22, 8'h00);
        // capture of the running count, then vector execution clears it
        capture_input_pin[0] = 1'b1;
        idle(1);
        capture_input_pin[0] = 1'b0;
        rd(8'h22, 8'h20);
        rd(8'h02, 8'h37);
        rd(8'h03, 8'h12);
        ack_en = 1'b1;
        idle(6);
        rd(8'h22, 8'h00);
        ack_en = 1'b0;
        // capture as ceiling: reaching it wraps the count and flags capture
        ceiling_is_capture[0] = 1'b1;
        idle(2);
        chk16(count_ceiling[0], 16'h1237);
        pulse_tick(0);
        chk16(counter_value[0], 16'h0000);
        rd(8'h22, 8'h20);
        wr(8'h22, 8'h20);
        // comparator as timer 1 capture source, counter now at zero
        ceiling_is_capture[0] = 1'b0;
        comparator_select = 1'b1;
        comparator_event = 1'b1;
        idle(1);
        comparator_event = 1'b0;
        comparator_select = 1'b0;
        rd(8'h22, 8'h20);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        wr(8'h22, 8'h20);
        wr(8'h21, 8'h3f);
        rd(8'h21, 8'h3f);
        // timer 3 load, compare pair, capture and overflow in extended flags
        wr(8'h11, 8'h5a);
        wr(8'h10, 8'hc3);
        wr(8'h15, 8'hab);
        wr(8'h14, 8'hcd);
        rd(8'h14, 8'hcd);
        rd(8'h15, 8'hab);
        overflow_event[1] = 1'b1;
        capture_input_pin[1] = 1'b1;
        idle(1);
        overflow_event[1] = 1'b0;
        capture_input_pin[1] = 1'b0;
        rd(8'h23, 8'h24);
        rd(8'h22, 8'h00);
        rd(8'h12, 8'hc3);
        rd(8'h13, 8'h5a);
        chk8({3'h0, irq_request[1]}, 8'h11);
        ack_en = 1'b1;
        idle(6);
        rd(8'h23, 8'h00);
        legacy_mode = 1'b1;
        rd(8'h21, 8'h00);
        wr(8'h21, 8'h00);
        legacy_mode = 1'b0;
        rd(8'h21, 8'h3f);
        summarize();
    end
endmodule
